/* src/accel_pkg.sv */
// Purpose: Shared constants and types for the accelerometer filter and activity block.
// Assumes: 50 MHz core clock, 32-bit APB register words.
// Notes: Field positions are given by the packed register structs below.
package accel_pkg;

  localparam int CLK_HZ = 50_000_000;

  localparam logic [7:0] CONFIG_OFS   = 8'h00;
  localparam logic [7:0] POWER_OFS    = 8'h04;
  localparam logic [7:0] THR_X_OFS    = 8'h08;
  localparam logic [7:0] THR_Y_OFS    = 8'h0C;
  localparam logic [7:0] THR_Z_OFS    = 8'h10;
  localparam logic [7:0] ACT_TIME_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS   = 8'h18;
  localparam logic [7:0] DATA_X_OFS   = 8'h1C;
  localparam logic [7:0] DATA_Y_OFS   = 8'h20;
  localparam logic [7:0] DATA_Z_OFS   = 8'h24;

  typedef struct packed {
    logic [18:0] rsvd;
    logic        loop_mode;
    logic        inact_int_map;
    logic        act_int_map;
    logic        act_lpf_en;
    logic        hpf_en;
    logic [1:0]  hpf_corner;
    logic [2:0]  bandwidth;
    logic [2:0]  output_sample_rate;
  } config_t;

  typedef struct packed {
    logic [27:0] rsvd;
    logic        low_noise;
    logic        settling_time_select;
    logic [1:0]  mode;
  } power_t;

  typedef struct packed {
    logic [18:0] rsvd;
    logic        activity_referenced_select;
    logic        axis_enable;
    logic [10:0] level;
  } thresh_t;

  typedef struct packed {
    logic signed [11:0] x;
    logic signed [11:0] y;
    logic signed [11:0] z;
  } accel_t;

  localparam config_t CONFIG_RST   = '0;
  localparam power_t  POWER_RST    = '0;
  localparam thresh_t THRESH_RST   = '0;
  localparam logic [7:0] ACT_TIME_RST = 8'h00;

  localparam int STAT_ACT   = 0;
  localparam int STAT_INACT = 1;
  localparam int STAT_AWAKE = 2;
  localparam int STAT_DRDY  = 3;

  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKE    = 2'h1;
  localparam logic [1:0] MODE_MEAS    = 2'h3;

  localparam logic [2:0] RATE_CODE_MAX  = 3'h4;
  localparam logic [2:0] RATE_CODE_6400 = 3'h4;
  localparam int HPF_BASE_SHIFT = 5;
  localparam int LPF_BASE_SHIFT = 3;
  localparam int FRAC_BITS      = 8;
  localparam int INACT_SCALE    = 2;

  localparam int SETTLE_LONG_MS   = 370;
  localparam int SETTLE_SHORT_MS  = 16;
  localparam int SETTLE_LONG_CYC  = SETTLE_LONG_MS * (CLK_HZ / 1000);
  localparam int SETTLE_SHORT_CYC = SETTLE_SHORT_MS * (CLK_HZ / 1000);
  localparam int ACT_TICK_US      = 6600;
  localparam int ACT_TICK_FAST_US = 3300;
  localparam int ACT_TICK_CYC     = ACT_TICK_US * (CLK_HZ / 1_000_000);
  localparam int ACT_TICK_FAST_CYC = ACT_TICK_FAST_US * (CLK_HZ / 1_000_000);
  localparam int ODR_MIN_PERIOD_NS = 2_500_000;
  localparam int ODR_MIN_CYC      = ODR_MIN_PERIOD_NS / (1_000_000_000 / CLK_HZ);

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_WAKE    = 3'b010,
    ST_MEAS    = 3'b100
  } op_state_t;

endpackage : accel_pkg

/* src/accel_filter_and_activity_detect.sv */
// Purpose: Output rate, filtering, settling and activity detection behind an APB slave.
// Assumes: The front end returns one sample with sample_valid per sample_request.
// Notes: APB answers with no wait state; unmapped addresses return pslverr.
//
// Overview of operation
// - Bandwidth selectable, resets to 200 Hz.
// - Bandwidth clamped to half the output rate.
// - One-pole IIR high-pass, two-bit corner code.
// - High-pass corner scales with output rate.
// - High-pass and low-pass may run together.
// - First sample withheld until settling elapses.
// - Settling select bit: 370 ms default, 16 ms.
// - Output rate 400 to 6400 Hz, 400 default.
// - Selectable low-noise operating mode.
// - Burst reads and writes across consecutive registers.
// - Loop configuration clears interrupts by itself.
// - Events flagged in status, routable to interrupt.
// - Motion-state flag shows moving or stationary.
// - Detection in wake-up, but no interrupt.
// - Bypassable averaging low-pass near 10 Hz.
// - Any enabled axis over threshold, shared timer.
// - One reference select bit, resets to absolute.
// - Referenced: difference from reference exceeds threshold.
// - Standby clears interrupts and blocks new ones.
// - Activity tick 6.6 ms, 3.3 ms at rate code 4 only; codes 5 to 7 run at 6400 but keep 6.6 ms.
`timescale 1ns/1ps
`default_nettype none

module accel_filter_and_activity_detect
  import accel_pkg::*;
#(
  parameter int unsigned SETTLE_LONG    = SETTLE_LONG_CYC,
  parameter int unsigned SETTLE_SHORT   = SETTLE_SHORT_CYC,
  parameter int unsigned ACT_TICK       = ACT_TICK_CYC,
  parameter int unsigned ACT_TICK_FAST  = ACT_TICK_FAST_CYC,
  parameter int unsigned ODR_BASE       = ODR_MIN_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sample_valid,
  input  wire accel_t      sample_in,
  output logic             sample_request,
  output logic             frontend_on,
  output logic      [2:0]  bandwidth_applied,
  output logic             low_noise_en,
  output logic             int_out
);

  config_t            cfg;
  power_t             pwr;
  thresh_t            thr [3];
  logic [7:0]         act_time;
  logic [3:0]         status;
  logic signed [11:0] data_out [3];
  op_state_t          state;
  op_state_t          next_state;
  logic [31:0]        odr_cnt;
  logic [31:0]        settle_cnt;
  logic               settled;
  logic signed [19:0] hp_st [3];
  logic signed [19:0] lp_st [3];
  logic signed [19:0] hp_out [3];
  logic signed [19:0] det [3];
  logic signed [11:0] ref_val [3];
  logic               ref_valid;
  logic               over;
  logic               any_en;
  logic [31:0]        tick_cnt;
  logic [7:0]         act_periods;
  logic [9:0]         inact_periods;
  logic               act_hold;
  logic               inact_hold;
  logic               act_event;
  logic               inact_event;
  logic               use_sample;
  logic               wr_en;
  logic               rd_en;
  logic               status_rd;
  logic [31:0]        rd_word;
  logic               rd_err;

  function automatic logic [12:0] mag(input logic signed [12:0] v);
    mag = v[12] ? 13'(-v) : 13'(v);
  endfunction : mag

  function automatic logic [31:0] shr(input int unsigned base, input logic [2:0] sh);
    shr = 32'(base) >> sh;
  endfunction : shr

  assign wr_en     = psel && penable && pready && pwrite;
  assign rd_en     = psel && penable && pready && !pwrite;
  assign status_rd = rd_en && (paddr == STATUS_OFS);
  assign use_sample = clk_en && sample_valid && settled && (state != ST_STANDBY);

  // Zero-wait slave: the answer is prepared in the setup cycle.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (paddr)
      CONFIG_OFS:   rd_word = cfg;
      POWER_OFS:    rd_word = pwr;
      THR_X_OFS:    rd_word = thr[0];
      THR_Y_OFS:    rd_word = thr[1];
      THR_Z_OFS:    rd_word = thr[2];
      ACT_TIME_OFS: rd_word = {24'h00_0000, act_time};
      STATUS_OFS:   rd_word = {28'h000_0000, status};
      DATA_X_OFS:   rd_word = {20'h0_0000, data_out[0]};
      DATA_Y_OFS:   rd_word = {20'h0_0000, data_out[1]};
      DATA_Z_OFS:   rd_word = {20'h0_0000, data_out[2]};
      default:      rd_err  = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      prdata  <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Each word has its own address, so a burst is simply back-to-back transfers.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg      <= CONFIG_RST;
      pwr      <= POWER_RST;
      thr[0]   <= THRESH_RST;
      thr[1]   <= THRESH_RST;
      thr[2]   <= THRESH_RST;
      act_time <= ACT_TIME_RST;
    end else if (clk_en && wr_en) begin
      unique case (paddr)
        CONFIG_OFS:   cfg      <= config_t'(pwdata);
        POWER_OFS:    pwr      <= power_t'(pwdata);
        THR_X_OFS:    thr[0]   <= thresh_t'(pwdata);
        THR_Y_OFS:    thr[1]   <= thresh_t'(pwdata);
        THR_Z_OFS:    thr[2]   <= thresh_t'(pwdata);
        ACT_TIME_OFS: act_time <= pwdata[7:0];
        default:      ;
      endcase
    end
  end

  always_comb begin
    unique case (pwr.mode)
      MODE_MEAS: next_state = ST_MEAS;
      MODE_WAKE: next_state = ST_WAKE;
      default:   next_state = ST_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_STANDBY;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Front-end controls; the clamp keeps the filter below Nyquist.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bandwidth_applied <= 3'h0;
      low_noise_en      <= 1'b0;
      frontend_on       <= 1'b0;
    end else if (clk_en) begin
      bandwidth_applied <= (cfg.bandwidth > cfg.output_sample_rate) ?
                           cfg.output_sample_rate : cfg.bandwidth;
      low_noise_en      <= pwr.low_noise;
      frontend_on       <= (state != ST_STANDBY);
    end
  end

  // Rate codes above the top rate fall back to the top rate.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      odr_cnt        <= 32'h0000_0000;
      sample_request <= 1'b0;
    end else if (clk_en) begin
      sample_request <= 1'b0;
      if (state == ST_STANDBY) begin
        odr_cnt <= 32'h0000_0000;
      end else if (odr_cnt + 32'h1 >= shr(ODR_BASE,
                   (cfg.output_sample_rate > RATE_CODE_MAX) ?
                   RATE_CODE_MAX : cfg.output_sample_rate)) begin
        odr_cnt        <= 32'h0000_0000;
        sample_request <= 1'b1;
      end else begin
        odr_cnt <= odr_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt <= 32'h0000_0000;
      settled    <= 1'b0;
    end else if (clk_en) begin
      if (state == ST_STANDBY) begin
        settle_cnt <= 32'h0000_0000;
        settled    <= 1'b0;
      end else if (!settled) begin
        settle_cnt <= settle_cnt + 32'h1;
        settled    <= settle_cnt + 32'h1 >= (pwr.settling_time_select ?
                      32'(SETTLE_SHORT) : 32'(SETTLE_LONG));
      end
    end
  end

  // A fixed coefficient per code keeps the corner a fixed fraction of the rate.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      hp_out[i] = {(i == 0) ? sample_in.x : (i == 1) ? sample_in.y : sample_in.z,
                   8'h00};
      if (cfg.hpf_en) begin
        hp_out[i] = hp_out[i] - hp_st[i];
      end
      det[i] = cfg.act_lpf_en ? lp_st[i] : hp_out[i];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        hp_st[i] <= 20'sh0_0000;
        lp_st[i] <= 20'sh0_0000;
      end
    end else if (clk_en && sample_valid && state != ST_STANDBY) begin
      for (int i = 0; i < 3; i++) begin
        hp_st[i] <= hp_st[i] + (hp_out[i] >>> (HPF_BASE_SHIFT + cfg.hpf_corner));
        lp_st[i] <= lp_st[i] + ((hp_out[i] - lp_st[i]) >>>
                    (LPF_BASE_SHIFT + cfg.output_sample_rate));
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        data_out[i] <= 12'sh000;
      end
    end else if (use_sample) begin
      for (int i = 0; i < 3; i++) begin
        data_out[i] <= hp_out[i][FRAC_BITS +: 12];
      end
    end
  end

  // Clearing the select bit drops the reference, so re-arming takes a new one.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ref_valid <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        ref_val[i] <= 12'sh000;
      end
    end else if (clk_en) begin
      if (!thr[0].activity_referenced_select) begin
        ref_valid <= 1'b0;
      end else if (use_sample && state == ST_MEAS && !ref_valid) begin
        ref_valid <= 1'b1;
        for (int i = 0; i < 3; i++) begin
          ref_val[i] <= det[i][FRAC_BITS +: 12];
        end
      end
    end
  end

  always_comb begin
    over   = 1'b0;
    any_en = 1'b0;
    for (int i = 0; i < 3; i++) begin
      any_en = any_en | thr[i].axis_enable;
      if (thr[i].axis_enable && (ref_valid || !thr[0].activity_referenced_select) &&
          mag(13'($signed(det[i][FRAC_BITS +: 12])) -
              (thr[0].activity_referenced_select ? 13'(ref_val[i]) : 13'sh0000))
          > {2'b00, thr[i].level}) begin
        over = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt      <= 32'h0000_0000;
      act_periods   <= 8'h00;
      inact_periods <= 10'h000;
    end else if (clk_en) begin
      if (state != ST_MEAS || !settled) begin
        tick_cnt      <= 32'h0000_0000;
        act_periods   <= 8'h00;
        inact_periods <= 10'h000;
      end else if (tick_cnt + 32'h1 >= ((cfg.output_sample_rate == RATE_CODE_6400) ?
                   32'(ACT_TICK_FAST) : 32'(ACT_TICK))) begin
        tick_cnt <= 32'h0000_0000;
        if (!act_hold && act_periods != 8'hFF) begin
          act_periods <= act_periods + 8'h01;
        end
        if (!inact_hold && inact_periods != 10'h3FF) begin
          inact_periods <= inact_periods + 10'h001;
        end
      end else begin
        tick_cnt <= tick_cnt + 32'h1;
      end
      if (use_sample && !over) begin
        act_periods <= 8'h00;
      end
      if (use_sample && over) begin
        inact_periods <= 10'h000;
      end
    end
  end

  always_comb begin
    act_event   = 1'b0;
    inact_event = 1'b0;
    if (use_sample && any_en) begin
      if (state == ST_WAKE) begin
        act_event = over && !act_hold;
      end else begin
        act_event   = over && !act_hold && act_periods >= act_time;
        inact_event = !over && !inact_hold &&
                      inact_periods >= {act_time, 2'b00};
      end
    end
  end

  // Holds stop one sustained condition from firing on every sample.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_hold   <= 1'b0;
      inact_hold <= 1'b0;
    end else if (clk_en) begin
      if (state == ST_STANDBY) begin
        act_hold   <= 1'b0;
        inact_hold <= 1'b0;
      end else if (use_sample) begin
        act_hold   <= over && (act_hold || act_event);
        inact_hold <= !over && (inact_hold || inact_event);
      end
    end
  end

  // An event in the cycle of a status read survives the read.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status <= 4'h0;
    end else if (clk_en) begin
      if (state == ST_STANDBY) begin
        status[STAT_ACT]   <= 1'b0;
        status[STAT_INACT] <= 1'b0;
      end else begin
        if (act_event) begin
          status[STAT_ACT]   <= 1'b1;
          status[STAT_AWAKE] <= 1'b1;
          if (cfg.loop_mode) begin
            status[STAT_INACT] <= 1'b0;
          end
        end else if (status_rd) begin
          status[STAT_ACT] <= 1'b0;
        end
        if (inact_event) begin
          status[STAT_INACT] <= 1'b1;
          status[STAT_AWAKE] <= 1'b0;
          if (cfg.loop_mode) begin
            status[STAT_ACT] <= 1'b0;
          end
        end else if (status_rd && !(act_event && cfg.loop_mode)) begin
          status[STAT_INACT] <= 1'b0;
        end
      end
      if (use_sample) begin
        status[STAT_DRDY] <= 1'b1;
      end else if (status_rd) begin
        status[STAT_DRDY] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      int_out <= 1'b0;
    end else if (clk_en) begin
      int_out <= (state == ST_MEAS) &&
                 ((status[STAT_ACT] && cfg.act_int_map) ||
                  (status[STAT_INACT] && cfg.inact_int_map));
    end
  end

endmodule : accel_filter_and_activity_detect

`default_nettype wire

/* testbench/accel_checker.sv */
// Purpose: Port-level checks of the filter and activity block.
// Assumes: Zero-wait APB slave and registered outputs as handed over.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module accel_checker
  import accel_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sample_valid,
  input wire accel_t      sample_in,
  input wire logic        sample_request,
  input wire logic        frontend_on,
  input wire logic [2:0]  bandwidth_applied,
  input wire logic        low_noise_en,
  input wire logic        int_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic       cfg_wr;
  logic       pwr_wr;
  logic [2:0] bw_q;
  logic       ln_q;
  logic       fe_q;
  logic       meas_q;
  assign cfg_wr = psel && penable && pready && pwrite && paddr == CONFIG_OFS;
  assign pwr_wr = psel && penable && pready && pwrite && paddr == POWER_OFS;
  // Expected values are captured at the write edge, since pwdata moves on afterwards.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bw_q <= 3'h0;
    end else if (cfg_wr) begin
      bw_q <= (pwdata[5:3] > pwdata[2:0]) ? pwdata[2:0] : pwdata[5:3];
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ln_q   <= 1'b0;
      fe_q   <= 1'b0;
      meas_q <= 1'b0;
    end else if (pwr_wr) begin
      ln_q   <= pwdata[3];
      fe_q   <= pwdata[1:0] == MODE_WAKE || pwdata[1:0] == MODE_MEAS;
      meas_q <= pwdata[1:0] == MODE_MEAS;
    end
  end
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("No answer in access cycle.");
  property p_idle; !(psel && !penable) |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("Answer without setup.");
  property p_unmapped; psel && !penable && paddr > DATA_Z_OFS |=> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped access not flagged.");
  property p_bw; cfg_wr |-> ##[1:2] bandwidth_applied == bw_q; endproperty
  a_bw: assert property (p_bw) else $error("Bandwidth not clamped to rate.");
  property p_ln; pwr_wr |-> ##[1:2] low_noise_en == ln_q; endproperty
  a_ln: assert property (p_ln) else $error("Low noise output wrong.");
  property p_fe; pwr_wr |-> ##3 frontend_on == fe_q; endproperty
  a_fe: assert property (p_fe) else $error("Front end state wrong.");
  property p_req; sample_request |=> !sample_request; endproperty
  a_req: assert property (p_req) else $error("Sample request longer than a cycle.");
  property p_req_off; !fe_q && $past(!fe_q) && $past(!fe_q, 2) |-> !sample_request; endproperty
  a_req_off: assert property (p_req_off) else $error("Sample request in standby.");
  property p_int; !meas_q && $past(!meas_q) && $past(!meas_q, 2) |-> !int_out; endproperty
  a_int: assert property (p_int) else $error("Interrupt outside measurement.");
endmodule : accel_checker
bind accel_filter_and_activity_detect accel_checker accel_checker_i (
  .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sample_valid(sample_valid), .sample_in(sample_in),
  .sample_request(sample_request), .frontend_on(frontend_on),
  .bandwidth_applied(bandwidth_applied), .low_noise_en(low_noise_en), .int_out(int_out)
);
`default_nettype wire

/* testbench/accel_frontend_model.sv */
// Purpose: Sensor front end that answers each sample request with one sample.
// Assumes: The bench sets the acceleration to present.
// Notes: Outside a valid pulse the bus toggles, so stale data never looks fresh.
`timescale 1ns/1ps
`default_nettype none
module accel_frontend_model
  import accel_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   nrst,
  input  wire logic   sample_request,
  input  wire accel_t val,
  output var logic    sample_valid,
  output var accel_t  sample_in
);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sample_valid <= 1'b0;
      sample_in    <= '0;
    end else if (sample_request) begin
      sample_valid <= 1'b1;
      sample_in    <= val;
    end else begin
      sample_valid <= 1'b0;
      sample_in    <= ~sample_in;
    end
  end
endmodule : accel_frontend_model
`default_nettype wire

/* testbench/tb.sv */
// Purpose: Register-level tests of rate, filters, settling and activity detection.
// Assumes: Short settling and rate counts set by parameters.
// Notes: Waits that follow settling are fixed by the parameter values below.
`timescale 1ns/1ps
`default_nettype none
module tb
  import accel_pkg::*;
;
  logic        core_clk;
  logic        nrst;
  logic        clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sample_valid;
  accel_t      sample_in;
  accel_t      val;
  logic        sample_request;
  logic        frontend_on;
  logic [2:0]  bandwidth_applied;
  logic        low_noise_en;
  logic        int_out;
  logic [31:0] r;
  logic        s;
  logic [31:0] cw;
  int          num_errors;
  int          checks;
  accel_filter_and_activity_detect #(.SETTLE_LONG(200), .SETTLE_SHORT(20), .ACT_TICK(16),
    .ACT_TICK_FAST(8), .ODR_BASE(64)) accel_filter_and_activity_detect_i (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_in(sample_in),
    .sample_request(sample_request), .frontend_on(frontend_on),
    .bandwidth_applied(bandwidth_applied), .low_noise_en(low_noise_en), .int_out(int_out));
  accel_frontend_model accel_frontend_model_i (.core_clk(core_clk), .nrst(nrst),
    .sample_request(sample_request), .val(val), .sample_valid(sample_valid),
    .sample_in(sample_in));
  always #10 core_clk = ~core_clk;
  task automatic results();
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      results();
    end
    r = prdata;
    s = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  // Standby first, so configuration changes and flag clearing happen while stopped.
  task automatic enter(input logic [31:0] cfg, input logic [31:0] pwr);
    apb(1'b1, POWER_OFS, 32'h0);
    apb(1'b1, CONFIG_OFS, cfg);
    apb(1'b0, STATUS_OFS, 32'h0);
    apb(1'b1, POWER_OFS, pwr);
  endtask : enter
  initial begin
    repeat (100000) @(posedge core_clk);
    num_errors++;
    results();
  end
  initial begin
    core_clk   = 1'b0;
    nrst       = 1'b0;
    clk_en     = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    val        = {12'h190, 24'h0};
    num_errors = 0;
    checks     = 0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    apb(1'b0, CONFIG_OFS, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, POWER_OFS, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, THR_X_OFS, 32'h0);
    chk(r, 32'h0);
    chk(bandwidth_applied, 3'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk(s, 1'b1);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      cw = 32'h18 | i | ((i & 3) << 6);
      apb(1'b1, CONFIG_OFS, cw);
      apb(1'b0, CONFIG_OFS, 32'h0);
      chk(r, cw);
      chk(bandwidth_applied, (i < 3) ? i : 3);
    end
    apb(1'b1, POWER_OFS, 32'h8);
    cyc(3);
    chk(low_noise_en, 1'b1);
    $display("rate and bandwidth test done");
    enter(32'h384, 32'h3);
    cyc(40);
    chk(frontend_on, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r[3], 1'b0);
    cyc(200);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r[3], 1'b1);
    apb(1'b0, DATA_X_OFS, 32'h0);
    chk($signed(r[11:0]) < 12'sd400, 1'b1);
    $display("long settling test done");
    enter(32'h4, 32'h7);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r[3], 1'b0);
    cyc(30);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r[3], 1'b1);
    apb(1'b0, DATA_X_OFS, 32'h0);
    chk(r[11:0], 12'h190);
    $display("short settling test done");
    apb(1'b1, POWER_OFS, 32'h0);
    apb(1'b1, THR_X_OFS, 32'h864);
    apb(1'b1, THR_Y_OFS, 32'h864);
    val.x <= 12'hF38;
    enter(32'h404, 32'h7);
    cyc(40);
    chk(int_out, 1'b1);
    apb(1'b1, POWER_OFS, 32'h0);
    cyc(3);
    chk(int_out, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r[0], 1'b0);
    $display("absolute activity test done");
    enter(32'h404, 32'h5);
    cyc(40);
    chk(int_out, 1'b0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r[0], 1'b1);
    $display("wake-up test done");
    apb(1'b1, POWER_OFS, 32'h0);
    apb(1'b1, THR_X_OFS, 32'h1864);
    val.x <= 12'h1F4;
    enter(32'h404, 32'h7);
    cyc(40);
    chk(int_out, 1'b0);
    val.x <= 12'h2BC;
    cyc(20);
    chk(int_out, 1'b1);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(r[0], 1'b1);
    $display("referenced activity test done");
    apb(1'b1, POWER_OFS, 32'h0);
    apb(1'b1, THR_X_OFS, 32'h864);
    apb(1'b1, ACT_TIME_OFS, 32'h2);
    val.x <= 12'hF38;
    enter(32'h404, 32'h7);
    cyc(30);
    chk(int_out, 1'b0);
    cyc(15);
    chk(int_out, 1'b1);
    $display("activity time test done");
    results();
  end
endmodule : tb
`default_nettype wire
